// *** rtl/cept_timer.v ***
// Cascaded 16-bit event counter / PWM timer with Avalon-MM register slave.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "cept_map.vh"

module cept_timer #(
    parameter FS_DIV = 1526
) (
    input  wire        i_clk,
    input  wire        i_reset,
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    input  wire        i_ext_count_pin,
    output wire        o_pwm_out_pin,
    output wire        o_cascade_irq
);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [7:0]  lower_timer_control_ff;
    reg  [7:0]  upper_timer_control_ff;
    reg  [7:0]  compare_low_byte_ff;
    reg  [7:0]  compare_high_byte_ff;
    reg  [15:0] duty_buf_ff;
    reg  [15:0] duty_act_ff;
    reg         duty_pend_ff;
    reg  [15:0] count_ff;
    reg         output_toggle_ff;
    reg         irq_ff;
    reg         ack_ff;
    reg  [10:0] pre_ff;
    reg  [15:0] fs_cnt_ff;
    reg  [2:0]  fs_pre_ff;
    reg         fs_tick_ff;

    wire        ext_fall;
    wire        wr_en;
    wire        rd_en;
    wire [2:0]  mode;
    wire        upper_run_bit;
    wire        out_ff_preset;
    wire        is_event;
    wire        is_pwm;
    wire [15:0] compare_val;
    wire [2:0]  src_sel;
    wire        divider_tap_select;
    wire        slow_sel;
    reg         tick;
    wire        cmp_hit;
    wire        duty_hit;
    wire        ovf_hit;

    assign mode               = upper_timer_control_ff[`CEPT_UC_MODE_MSB:`CEPT_UC_MODE_LSB];
    assign upper_run_bit      = upper_timer_control_ff[`CEPT_UC_RUN_BIT];
    assign out_ff_preset      = upper_timer_control_ff[`CEPT_UC_PRESET_BIT];
    assign is_event           = (mode == `CEPT_MODE_EVENT);
    assign is_pwm             = (mode == `CEPT_MODE_PWM);
    assign compare_val        = {compare_high_byte_ff, compare_low_byte_ff};
    assign src_sel            = lower_timer_control_ff[`CEPT_LC_SRC_MSB:`CEPT_LC_SRC_LSB];
    assign divider_tap_select = lower_timer_control_ff[`CEPT_LC_TAP_BIT];
    assign slow_sel           = lower_timer_control_ff[`CEPT_LC_SLOW_BIT];

    // ------------------------------------------------------------------------
    // Avalon-MM slave: one wait state on every access.
    // ------------------------------------------------------------------------
    assign rd_en             = i_avs_read & ~ack_ff;
    // Writes land at the edge where waitrequest is low, together with the transfer.
    assign wr_en             = i_avs_write & ack_ff;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;

    function [7:0] merge_byte;
        input [7:0] old_val;
        input [7:0] new_val;
        input       lane_en;
        begin
            merge_byte = lane_en ? new_val : old_val;
        end
    endfunction

    function wr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        input       en;
        begin
            wr_hit = en & (addr == ofs);
        end
    endfunction

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ack_ff         <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else begin
            ack_ff <= (i_avs_read | i_avs_write) & ~ack_ff;
            if (rd_en) begin
                case (i_avs_address)
                    `CEPT_OFS_LOWER_CTRL: o_avs_readdata <= {24'h000000, lower_timer_control_ff};
                    `CEPT_OFS_UPPER_CTRL: o_avs_readdata <= {24'h000000, upper_timer_control_ff};
                    `CEPT_OFS_CMP_LOW:    o_avs_readdata <= {24'h000000, compare_low_byte_ff};
                    `CEPT_OFS_CMP_HIGH:   o_avs_readdata <= {24'h000000, compare_high_byte_ff};
                    `CEPT_OFS_DUTY_LOW:   o_avs_readdata <= {24'h000000, duty_act_ff[7:0]};
                    `CEPT_OFS_DUTY_HIGH:  o_avs_readdata <= {24'h000000, duty_act_ff[15:8]};
                    `CEPT_OFS_COUNT:      o_avs_readdata <= {16'h0000, count_ff};
                    default:              o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Prescaler and low-frequency clock enable
    // ------------------------------------------------------------------------
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pre_ff     <= 11'h000;
            fs_cnt_ff  <= `CEPT_RST_WORD;
            fs_pre_ff  <= 3'h0;
            fs_tick_ff <= 1'b0;
        end else begin
            pre_ff     <= pre_ff + 11'h001;
            fs_tick_ff <= 1'b0;
            if (fs_cnt_ff == FS_DIV[15:0] - 16'h0001) begin
                fs_cnt_ff  <= `CEPT_RST_WORD;
                fs_tick_ff <= 1'b1;
                fs_pre_ff  <= fs_pre_ff + 3'h1;
            end else begin
                fs_cnt_ff <= fs_cnt_ff + 16'h0001;
            end
        end
    end

    cept_edge_sync u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pin   (i_ext_count_pin),
        .o_fall  (ext_fall)
    );

    // Count enable selection; outside event mode, slow operation forces fs/8 or fs.
    always @* begin
        tick = 1'b0;
        if (is_event) begin
            tick = ext_fall;
        end else if (slow_sel) begin
            if (src_sel == `CEPT_SRC_FS) begin
                tick = fs_tick_ff;
            end else begin
                tick = fs_tick_ff & (fs_pre_ff == 3'h7);
            end
        end else begin
            case (src_sel)
                `CEPT_SRC_DIV11: tick = divider_tap_select ? (fs_tick_ff & (fs_pre_ff == 3'h7))
                                                           : (pre_ff == 11'h7ff);
                `CEPT_SRC_DIV7:  tick = (pre_ff[6:0] == 7'h7f);
                `CEPT_SRC_DIV5:  tick = (pre_ff[4:0] == 5'h1f);
                `CEPT_SRC_DIV3:  tick = (pre_ff[2:0] == 3'h7);
                `CEPT_SRC_FS:    tick = fs_tick_ff;
                `CEPT_SRC_DIV1:  tick = pre_ff[0];
                `CEPT_SRC_FC:    tick = 1'b1;
                `CEPT_SRC_EXT:   tick = ext_fall;
                default:         tick = 1'b0;
            endcase
        end
    end

    assign cmp_hit  = is_event & upper_run_bit & tick & (count_ff == compare_val);
    assign duty_hit = is_pwm & upper_run_bit & tick & (count_ff == duty_act_ff);
    assign ovf_hit  = is_pwm & upper_run_bit & tick & (count_ff == `CEPT_CNT_MAX);

    // ------------------------------------------------------------------------
    // Control, compare and duty registers
    // ------------------------------------------------------------------------
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            lower_timer_control_ff <= `CEPT_RST_BYTE;
            upper_timer_control_ff <= `CEPT_RST_BYTE;
            compare_low_byte_ff    <= `CEPT_RST_BYTE;
            compare_high_byte_ff   <= `CEPT_RST_BYTE;
            duty_buf_ff            <= `CEPT_RST_WORD;
            duty_act_ff            <= `CEPT_RST_WORD;
            duty_pend_ff           <= 1'b0;
        end else begin
            if (wr_hit(i_avs_address, `CEPT_OFS_LOWER_CTRL, wr_en)) begin
                lower_timer_control_ff <= merge_byte(lower_timer_control_ff, i_avs_writedata[7:0],
                                                     i_avs_byteenable[0]);
            end
            if (wr_hit(i_avs_address, `CEPT_OFS_UPPER_CTRL, wr_en)) begin
                upper_timer_control_ff <= merge_byte(upper_timer_control_ff, i_avs_writedata[7:0],
                                                     i_avs_byteenable[0]);
            end
            if (wr_hit(i_avs_address, `CEPT_OFS_CMP_LOW, wr_en)) begin
                compare_low_byte_ff <= merge_byte(compare_low_byte_ff, i_avs_writedata[7:0],
                                                  i_avs_byteenable[0]);
            end
            if (wr_hit(i_avs_address, `CEPT_OFS_CMP_HIGH, wr_en)) begin
                compare_high_byte_ff <= merge_byte(compare_high_byte_ff, i_avs_writedata[7:0],
                                                   i_avs_byteenable[0]);
            end
            if (wr_hit(i_avs_address, `CEPT_OFS_DUTY_LOW, wr_en)) begin
                duty_buf_ff[7:0] <= merge_byte(duty_buf_ff[7:0], i_avs_writedata[7:0], i_avs_byteenable[0]);
            end
            // High byte completes the pair; the transfer is immediate when stopped, deferred to overflow when running.
            if (wr_hit(i_avs_address, `CEPT_OFS_DUTY_HIGH, wr_en)) begin
                if (upper_run_bit) begin
                    duty_buf_ff[15:8] <= merge_byte(duty_buf_ff[15:8], i_avs_writedata[7:0],
                                                    i_avs_byteenable[0]);
                    duty_pend_ff      <= 1'b1;
                end else begin
                    duty_act_ff <= {merge_byte(duty_buf_ff[15:8], i_avs_writedata[7:0], i_avs_byteenable[0]),
                                    duty_buf_ff[7:0]};
                    duty_buf_ff[15:8] <= merge_byte(duty_buf_ff[15:8], i_avs_writedata[7:0],
                                                    i_avs_byteenable[0]);
                    duty_pend_ff      <= 1'b0;
                end
            end else if (ovf_hit & duty_pend_ff) begin
                duty_act_ff  <= duty_buf_ff;
                duty_pend_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Counter, output flip-flop and cascade interrupt
    // ------------------------------------------------------------------------
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count_ff         <= `CEPT_RST_WORD;
            output_toggle_ff <= 1'b0;
            irq_ff           <= 1'b0;
        end else begin
            irq_ff <= cmp_hit | ovf_hit;
            if (!upper_run_bit) begin
                count_ff <= `CEPT_RST_WORD;
                // Stopped: flip-flop follows preset, pin held otherwise.
                if (wr_hit(i_avs_address, `CEPT_OFS_UPPER_CTRL, wr_en) & i_avs_byteenable[0] &
                    ~i_avs_writedata[`CEPT_UC_RUN_BIT]) begin
                    output_toggle_ff <= i_avs_writedata[`CEPT_UC_PRESET_BIT];
                end
            end else if (tick) begin
                if (cmp_hit) begin
                    count_ff <= `CEPT_RST_WORD;
                end else if (ovf_hit) begin
                    count_ff         <= `CEPT_RST_WORD;
                    output_toggle_ff <= ~output_toggle_ff;
                end else begin
                    count_ff <= count_ff + 16'h0001;
                    if (duty_hit) begin
                        output_toggle_ff <= ~output_toggle_ff;
                    end
                end
            end
        end
    end

    assign o_pwm_out_pin = ~output_toggle_ff;
    assign o_cascade_irq = irq_ff;

endmodule

// *** rtl/cept_map.vh ***
// Register map, field positions and reset values of the cascaded event/PWM timer.
`ifndef CEPT_MAP_VH
`define CEPT_MAP_VH

// ----------------------------------------------------------------------------
// Register word offsets (word addresses)
// ----------------------------------------------------------------------------
`define CEPT_ADDR_W          4
`define CEPT_OFS_LOWER_CTRL  4'h0
`define CEPT_OFS_UPPER_CTRL  4'h1
`define CEPT_OFS_CMP_LOW     4'h2
`define CEPT_OFS_CMP_HIGH    4'h3
`define CEPT_OFS_DUTY_LOW    4'h4
`define CEPT_OFS_DUTY_HIGH   4'h5
`define CEPT_OFS_COUNT       4'h6

// ----------------------------------------------------------------------------
// Upper control fields
// ----------------------------------------------------------------------------
`define CEPT_UC_MODE_LSB     0
`define CEPT_UC_MODE_MSB     2
`define CEPT_UC_RUN_BIT      3
`define CEPT_UC_PRESET_BIT   7
`define CEPT_MODE_EVENT      3'h1
`define CEPT_MODE_PWM        3'h2

// ----------------------------------------------------------------------------
// Lower control fields
// ----------------------------------------------------------------------------
`define CEPT_LC_SRC_LSB      4
`define CEPT_LC_SRC_MSB      6
`define CEPT_LC_TAP_BIT      0
`define CEPT_LC_SLOW_BIT     1

// ----------------------------------------------------------------------------
// Count source codes
// ----------------------------------------------------------------------------
`define CEPT_SRC_DIV11       3'h0
`define CEPT_SRC_DIV7        3'h1
`define CEPT_SRC_DIV5        3'h2
`define CEPT_SRC_DIV3        3'h3
`define CEPT_SRC_FS          3'h4
`define CEPT_SRC_DIV1        3'h5
`define CEPT_SRC_FC          3'h6
`define CEPT_SRC_EXT         3'h7

// ----------------------------------------------------------------------------
// Reset values and counter maximum
// ----------------------------------------------------------------------------
`define CEPT_RST_BYTE        8'h00
`define CEPT_RST_WORD        16'h0000
`define CEPT_CNT_MAX         16'hffff

`endif

// *** rtl/cept_edge_sync.v ***
// Synchroniser and falling-edge detector for the external count pin.
`timescale 1ns/10ps

module cept_edge_sync (
    input  wire i_clk,
    input  wire i_reset,
    input  wire i_pin,
    output wire o_fall
);

    // ------------------------------------------------------------------------
    // Two-stage synchroniser, third stage for edge detection.
    // ------------------------------------------------------------------------
    reg meta_ff;
    reg sync_ff;
    reg prev_ff;

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= i_pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign o_fall = prev_ff & ~sync_ff;

endmodule

// *** dv/cept_timer_chk.sv ***
// Port checker for the cascaded event/PWM timer.
`timescale 1ns/10ps
`include "cept_map.vh"
module cept_timer_chk (
    input wire        i_clk,
    input wire        i_reset,
    input wire [3:0]  i_avs_address,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0]  i_avs_byteenable,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest,
    input wire        i_ext_count_pin,
    input wire        o_pwm_out_pin,
    input wire        o_cascade_irq
);
    // ------------------------------------------------------------------
    // Shadow of run and mode, and age of the last pin fall
    // ------------------------------------------------------------------
    reg       run_ff;
    reg [2:0] mode_ff;
    reg [3:0] age_ff;
    reg       pin_ff;
    wire      req = i_avs_read || i_avs_write;
    wire      wr_uc = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h1 && i_avs_byteenable[0];
    wire      rd_ok = i_avs_read && !o_avs_waitrequest;
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            run_ff  <= 1'b0;
            mode_ff <= 3'h0;
            age_ff  <= 4'hf;
            pin_ff  <= 1'b1;
        end else begin
            pin_ff <= i_ext_count_pin;
            if (wr_uc) begin
                run_ff  <= i_avs_writedata[`CEPT_UC_RUN_BIT];
                mode_ff <= i_avs_writedata[2:0];
            end
            if (pin_ff && !i_ext_count_pin)
                age_ff <= 4'h0;
            else if (age_ff != 4'hf)
                age_ff <= age_ff + 4'h1;
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    first_wait_a: assert property ($rose(req) |-> o_avs_waitrequest) else $error("no wait state");
    one_wait_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("wait too long");
    idle_nowait_a: assert property (!req |-> !o_avs_waitrequest) else $error("wait while idle");
    irq_pulse_a: assert property (o_cascade_irq |=> !o_cascade_irq) else $error("irq too long");
    irq_run_a: assert property (o_cascade_irq |-> $past(run_ff)) else $error("irq while stopped");
    event_edge_a: assert property (o_cascade_irq && mode_ff == `CEPT_MODE_EVENT |-> age_ff <= 4'h6)
        else $error("event irq without pin fall");
    stop_hold_a: assert property (!run_ff && !$past(run_ff) && $changed(o_pwm_out_pin)
        |-> $past(wr_uc) || $past(wr_uc, 2)) else $error("stopped pin moved");
    reset_level_a: assert property ($fell(i_reset) |-> o_pwm_out_pin && !o_cascade_irq)
        else $error("bad level after reset");
    unmapped_zero_a: assert property (rd_ok && i_avs_address > 4'h6 |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    byte_read_a: assert property (rd_ok && i_avs_address < 4'h6 |-> o_avs_readdata[31:8] == 24'h0)
        else $error("byte register upper bits set");
    ev_irq_c: cover property (o_cascade_irq && mode_ff == `CEPT_MODE_EVENT);
    pwm_irq_c: cover property (o_cascade_irq && mode_ff == `CEPT_MODE_PWM);
    pwm_turn_c: cover property (run_ff && $changed(o_pwm_out_pin));
endmodule

bind cept_timer cept_timer_chk i_chk (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_ext_count_pin(i_ext_count_pin),
    .o_pwm_out_pin(o_pwm_out_pin), .o_cascade_irq(o_cascade_irq));

// *** dv/cept_pulse_src.sv ***
// External pulse source model that drives the count pin.
`timescale 1ns/10ps
module cept_pulse_src (
    input  wire       i_clk,
    input  wire       i_reset,
    input  wire [7:0] i_count,
    input  wire       i_go,
    output reg        o_pin,
    output wire       o_busy
);
    reg [7:0] left_ff;
    reg [2:0] phase_ff;
    assign o_busy = left_ff != 8'h00;
    // Each phase lasts three clocks, above the two-cycle minimum.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pin    <= 1'b1;
            left_ff  <= 8'h00;
            phase_ff <= 3'h0;
        end else if (left_ff == 8'h00) begin
            phase_ff <= 3'h0;
            if (i_go)
                left_ff <= i_count;
        end else begin
            phase_ff <= phase_ff + 3'h1;
            if (phase_ff == 3'h2)
                o_pin <= 1'b0;
            if (phase_ff == 3'h5) begin
                o_pin    <= 1'b1;
                phase_ff <= 3'h0;
                left_ff  <= left_ff - 8'h01;
            end
        end
    end
endmodule

// *** dv/tb.sv ***
// Self-checking testbench for the cascaded event/PWM timer.
`timescale 1ns/10ps
module tb;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [31:0] wdata = 32'h0;
    reg  [3:0]  be = 4'h1;
    reg         go = 1'b0;
    reg  [7:0]  npulse = 8'h00;
    wire [31:0] rdata;
    wire        wreq;
    wire        pin;
    wire        pwm;
    wire        irq;
    wire        busy;
    integer     fail_count = 0;
    integer     n_checks = 0;
    integer     irq_cnt = 0;
    cept_timer #(.FS_DIV(4)) i_dut (.i_clk(clk), .i_reset(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_ext_count_pin(pin), .o_pwm_out_pin(pwm), .o_cascade_irq(irq));
    cept_pulse_src i_src (.i_clk(clk), .i_reset(rst), .i_count(npulse), .i_go(go), .o_pin(pin), .o_busy(busy));
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (irq === 1'b1)
            irq_cnt <= irq_cnt + 1;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task bus(input w, input [3:0] a, input [7:0] d, output [31:0] q);
        integer n;
        begin
            @(posedge clk);
            addr  <= a;
            wdata <= {24'h0, d};
            rd    <= !w;
            wr    <= w;
            n = 0;
            @(posedge clk);
            while (wreq !== 1'b0 && n < 16) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 16)
                fail_count = fail_count + 1;
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task wrt(input [3:0] a, input [7:0] d);
        reg [31:0] q;
        begin
            bus(1'b1, a, d, q);
        end
    endtask
    task rdc(input [3:0] a, input [31:0] e);
        reg [31:0] q;
        begin
            bus(1'b0, a, 8'h00, q);
            chk(q, e);
        end
    endtask
    task pulses(input [7:0] k);
        integer n;
        begin
            @(posedge clk);
            npulse <= k;
            go     <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            n = 0;
            @(posedge clk);
            while (busy !== 1'b0 && n < 4000) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 4000)
                fail_count = fail_count + 1;
            repeat (6) @(posedge clk);
        end
    endtask
    task t_reset;
        integer a;
        begin
            chk(pwm, 1'b1);
            chk(irq, 1'b0);
            for (a = 0; a < 8; a = a + 1) rdc(a[3:0], 32'h0);
            for (a = 0; a < 8; a = a + 1) begin
                wrt(4'h0, {1'b0, a[2:0], 3'h0, a[0]});
                rdc(4'h0, {25'h0, a[2:0], 3'h0, a[0]});
            end
            // A write with its byte lane disabled must leave the register alone.
            be <= 4'h0;
            wrt(4'h0, 8'h00);
            rdc(4'h0, 32'h71);
            be <= 4'h1;
            $display("test reset done");
        end
    endtask
    task t_event;
        integer c0;
        begin
            wrt(4'h0, 8'h70);
            wrt(4'h2, 8'h03);
            wrt(4'h3, 8'h00);
            wrt(4'h1, 8'h09);
            c0 = irq_cnt;
            pulses(8'd3);
            rdc(4'h6, 32'h3);
            chk(irq_cnt - c0, 0);
            pulses(8'd1);
            chk(irq_cnt - c0, 1);
            rdc(4'h6, 32'h0);
            pulses(8'd2);
            rdc(4'h6, 32'h2);
            wrt(4'h2, 8'h02);
            pulses(8'd1);
            chk(irq_cnt - c0, 2);
            rdc(4'h6, 32'h0);
            wrt(4'h1, 8'h01);
            $display("test event done");
        end
    endtask
    task t_pwm;
        integer n;
        integer c0;
        reg [31:0] q;
        begin
            wrt(4'h0, 8'h60);
            wrt(4'h4, 8'h10);
            wrt(4'h5, 8'h00);
            rdc(4'h4, 32'h10);
            wrt(4'h1, 8'h0a);
            n = 0;
            while (pwm === 1'b1 && n < 200) begin
                @(posedge clk);
                n = n + 1;
            end
            chk(pwm, 1'b0);
            bus(1'b0, 4'h6, 8'h00, q);
            chk(q[31:4], 28'h1);
            wrt(4'h4, 8'h20);
            wrt(4'h5, 8'h00);
            rdc(4'h4, 32'h10);
            c0 = irq_cnt;
            n = 0;
            while (irq_cnt == c0 && n < 70000) begin
                @(posedge clk);
                n = n + 1;
            end
            chk(irq_cnt - c0, 1);
            chk(pwm, 1'b1);
            n = 0;
            while (pwm === 1'b1 && n < 200) begin
                @(posedge clk);
                n = n + 1;
            end
            chk(pwm, 1'b0);
            bus(1'b0, 4'h6, 8'h00, q);
            chk(q[31:4], 28'h2);
            wrt(4'h1, 8'h02);
            repeat (40) @(posedge clk);
            chk(pwm, 1'b0);
            rdc(4'h4, 32'h20);
            wrt(4'h1, 8'h02);
            @(posedge clk);
            chk(pwm, 1'b1);
            wrt(4'h1, 8'h82);
            @(posedge clk);
            chk(pwm, 1'b0);
            wrt(4'h1, 8'h02);
            @(posedge clk);
            chk(pwm, 1'b1);
            $display("test pwm done");
        end
    endtask
    task src_run(input [7:0] lc, input [31:0] e);
        begin
            wrt(4'h0, lc);
            wrt(4'h1, 8'h0a);
            repeat (255) @(posedge clk);
            rdc(4'h6, e);
            wrt(4'h1, 8'h02);
        end
    endtask
    task t_src;
        begin
            // Each run counts exactly 256 clocks; fs is one enable every 4 clocks here.
            src_run(8'h50, 32'h80);
            src_run(8'h30, 32'h20);
            src_run(8'h20, 32'h08);
            src_run(8'h10, 32'h02);
            src_run(8'h40, 32'h40);
            src_run(8'h01, 32'h08);
            src_run(8'h42, 32'h40);
            src_run(8'h32, 32'h08);
            wrt(4'h0, 8'h70);
            wrt(4'h1, 8'h0a);
            pulses(8'd3);
            rdc(4'h6, 32'h3);
            wrt(4'h1, 8'h02);
            $display("test source done");
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #(90000 * 20);
        fail_count = fail_count + 1;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_event;
        t_pwm;
        t_src;
        close_out;
    end
endmodule
